// ---- logic/tscr_pkg.sv ----
// Shared constants for the transparent serial channel register bank.
package tscr_pkg;

    // ============================================================
    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // ============================================================
    // Register byte addresses
    localparam logic [9:0] ADDR_MODE = 10'h000;
    localparam logic [9:0] ADDR_EVENT = 10'h004;
    localparam logic [9:0] ADDR_ENABLE = 10'h008;

    // Reserved parameter words, kept as word indexes; byte address is four times the index.
    localparam logic [7:0] PRAM_RES_FIRST = 8'h9C;
    localparam logic [7:0] PRAM_RES_LAST = 8'hBE;

    // ============================================================
    // Mode register layout
    localparam int MODE_W = 16;
    localparam int MODE_PROTO_LSB = 6;
    localparam int MODE_PROTO_MSB = 15;
    localparam int MODE_COMMON_W = 6;
    localparam int MODE_OUTSIDE_SYNC_BIT = 14;
    localparam int MODE_NO_SYNC_BIT = 13;
    localparam int MODE_BIT_REVERSE_BIT = 12;
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_SEL_W = 2;
    localparam logic [15:0] MODE_RESET = 16'h0000;

    // ============================================================
    // Event and enable layout
    localparam int EVT_W = 8;
    localparam int EVT_RX_BIT = 0;
    localparam int EVT_TX_BIT = 1;
    localparam int EVT_NO_BUFFER_BIT = 2;
    localparam int EVT_RECEIVE_WORD_BIT = 3;
    localparam int EVT_TRANSMIT_ERROR_BIT = 4;
    localparam int EVT_CARRIER_CHANGE_BIT = 6;
    localparam int EVT_CTS_CHANGE_BIT = 7;
    localparam logic [7:0] EVT_DEFINED = 8'hDF;
    localparam logic [7:0] EVT_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

endpackage : tscr_pkg

// ---- logic/tscr_sticky_flags.sv ----
// Sticky event flags with write-one-to-clear and set priority.
`timescale 1ns/1ps
`default_nettype none

module tscr_sticky_flags #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] VALID = '1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Set and clear
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] clear_mask,
    // State
    output logic [WIDTH-1:0] flags
);

    // ============================================================
    // Next value
    logic [WIDTH-1:0] next_flags;

    // A set in the clearing cycle survives, so no event is lost.
    assign next_flags = ((flags & ~clear_mask) | set_pulse) & VALID;

    // ============================================================
    // Storage
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

endmodule : tscr_sticky_flags

`default_nettype wire

// ---- logic/tscr_regs.sv ----
// Register bank of one serial channel in transparent mode, Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - The channel has a 16-bit memory-mapped read-write mode register that governs it.
// - Mode bits 15 to 6 carry transparent meaning only in transparent mode; bits 5 to 0 stay common.
// - Reset clears the protocol-specific mode bits to zero.
// - An 8-bit event register reports channel events and sources the interrupt.
// - A recognised event sets its event bit, which stays set until software clears it.
// - Writing one to an event bit clears it and writing zero leaves it alone.
// - An 8-bit read-write enable register matches the event bits one for one.
// - An enable bit at one lets its event request an interrupt, at zero it blocks it.
// - Reset clears both the event and the enable register.
// - Parameter words 9C through BE are reserved in transparent mode and hold no values.
// - The interrupt request stays high until every enabled event bit is cleared.
// - One write with several ones clears several event bits at once.
module tscr_regs
    import tscr_pkg::*;
#(
    parameter logic [1:0] TRANSPARENT_SEL = 2'h3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Events from the serial bit engine, one-cycle pulses on ref_clk
    input wire logic [EVT_W-1:0] event_pulse,
    // Mode controls to the serial bit engine
    output logic [MODE_COMMON_W-1:0] common_mode,
    output logic transparent_active,
    output logic outside_sync_select,
    output logic no_sync_select,
    output logic bit_order_reverse,
    // Interrupt
    output logic irq
);

    // ============================================================
    // Helpers

    // Merges write data into a 16-bit register under byte enables.
    function automatic logic [15:0] merge16(
        input logic [15:0] cur,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [15:0] res;
        res = cur;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : merge16

    // Word index of a byte address.
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction : word_index

    // ============================================================
    // Bus handshake
    // The answer comes one cycle after the request is seen; that costs a cycle
    // per access but lets read data come straight from a flip-flop.
    logic req;
    logic accept;
    logic wr_accept;
    logic next_waitrequest;

    assign req = avs_read | avs_write;
    assign accept = req & ~avs_waitrequest;
    assign wr_accept = avs_write & ~avs_waitrequest;
    assign next_waitrequest = ~(req & avs_waitrequest);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= next_waitrequest;
        end
    end

    // ============================================================
    // Address decode
    logic [7:0] idx;
    logic hit_mode;
    logic hit_event;
    logic hit_enable;
    logic hit_pram_res;
    logic [7:0] res_offset;

    assign idx = word_index(avs_address);
    assign hit_mode = (avs_address == ADDR_MODE);
    assign hit_event = (avs_address == ADDR_EVENT);
    assign hit_enable = (avs_address == ADDR_ENABLE);
    assign res_offset = idx - PRAM_RES_FIRST;
    assign hit_pram_res = (idx >= PRAM_RES_FIRST) && (idx <= PRAM_RES_LAST) && !res_offset[0];

    // ============================================================
    // Mode register
    logic [MODE_W-1:0] mode;
    logic [MODE_W-1:0] next_mode;
    logic mode_we;

    assign mode_we = wr_accept & hit_mode;
    assign next_mode = mode_we ? merge16(mode, avs_writedata, avs_byteenable) : mode;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mode <= MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // ============================================================
    // Mode decode
    // Undefined protocol bits are stored and read back as written, so software
    // that ignores the advice to write them zero sees its own value.
    logic next_transparent;
    logic next_outside_sync;
    logic next_no_sync;
    logic next_reverse;

    // protocol bits count only in transparent mode
    assign next_transparent = (next_mode[MODE_SEL_LSB +: MODE_SEL_W] == TRANSPARENT_SEL);
    assign next_outside_sync = next_transparent & next_mode[MODE_OUTSIDE_SYNC_BIT];
    assign next_no_sync = next_transparent & next_mode[MODE_NO_SYNC_BIT];
    assign next_reverse = next_transparent & next_mode[MODE_BIT_REVERSE_BIT];

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            common_mode <= MODE_RESET[MODE_COMMON_W-1:0];
            transparent_active <= 1'b0;
            outside_sync_select <= 1'b0;
            no_sync_select <= 1'b0;
            bit_order_reverse <= 1'b0;
        end else begin
            common_mode <= next_mode[MODE_COMMON_W-1:0];
            transparent_active <= next_transparent;
            outside_sync_select <= next_outside_sync;
            no_sync_select <= next_no_sync;
            bit_order_reverse <= next_reverse;
        end
    end

    // ============================================================
    // Event register
    logic [EVT_W-1:0] event_flags;
    logic [EVT_W-1:0] event_clear;
    logic event_we;

    assign event_we = wr_accept & hit_event & avs_byteenable[0];
    assign event_clear = event_we ? avs_writedata[EVT_W-1:0] : '0;

    tscr_sticky_flags #(
        .WIDTH(EVT_W),
        .VALID(EVT_DEFINED)
    ) u_event_flags (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .set_pulse(event_pulse),
        .clear_mask(event_clear),
        .flags(event_flags)
    );

    // ============================================================
    // Enable register
    logic [EVT_W-1:0] event_enable;
    logic [EVT_W-1:0] next_enable;
    logic enable_we;

    assign enable_we = wr_accept & hit_enable & avs_byteenable[0];
    assign next_enable = enable_we ? (avs_writedata[EVT_W-1:0] & EVT_DEFINED) : event_enable;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            event_enable <= ENABLE_RESET;
        end else begin
            event_enable <= next_enable;
        end
    end

    // ============================================================
    // Interrupt request
    logic next_irq;

    // high while any enabled event remains
    assign next_irq = |(event_flags & event_enable);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ============================================================
    // Read data
    // Unmapped and reserved addresses read as zero and ignore writes.
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] next_readdata;

    assign rd_mux = hit_mode ? {16'h0000, mode} :
                    hit_event ? {24'h000000, event_flags} :
                    hit_enable ? {24'h000000, event_enable} :
                    32'h00000000;
    // no protocol values in reserved words
    assign next_readdata = (avs_read && avs_waitrequest && !hit_pram_res) ? rd_mux :
                           (accept ? avs_readdata : 32'h00000000);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else begin
            avs_readdata <= next_readdata;
        end
    end

endmodule : tscr_regs

`default_nettype wire

// ---- dv/tscr_host_irq.sv ----
// Host interrupt controller model that counts interrupt requests.
`timescale 1ns/1ps
`default_nettype none
module tscr_host_irq (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Interrupt line and request count
    input wire logic irq,
    output int irq_rises
);
    logic irq_q;
    // ============================================================
    // Counting edges, not levels, shows a request that drops and comes back.
    always @(posedge ref_clk) begin
        irq_q <= irq;
        irq_rises <= !reset_n ? 0 : irq_rises + int'(irq && !irq_q);
    end
endmodule : tscr_host_irq
`default_nettype wire

// ---- dv/tscr_regs_monitor.sv ----
// Port checks for the register bank.
`timescale 1ns/1ps
`default_nettype none
module tscr_regs_monitor
    import tscr_pkg::*;
#(
    parameter logic [1:0] TRANSPARENT_SEL = 2'h3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Events, mode and interrupt
    input wire logic [EVT_W-1:0] event_pulse,
    input wire logic [MODE_COMMON_W-1:0] common_mode,
    input wire logic transparent_active,
    input wire logic outside_sync_select,
    input wire logic no_sync_select,
    input wire logic bit_order_reverse,
    input wire logic irq
);
    // ============================================================
    // Helpers
    wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire logic wr_mode = wr_done && (avs_address == ADDR_MODE);
    wire logic wr_evt = wr_done && (avs_address == ADDR_EVENT);
    wire logic wr_en = wr_done && (avs_address == ADDR_ENABLE);
    wire logic ev_any = |event_pulse;
    wire logic wsel = (avs_writedata[1:0] == TRANSPARENT_SEL);
    wire logic [5:0] wd_lo = avs_writedata[5:0];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ============================================================
    // Assertions
    chk_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    chk_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    chk_mode_common: assert property (wr_mode |=> ##1 common_mode == $past(wd_lo, 2))
        else $error("common mode bits wrong");
    chk_mode_select: assert property (wr_mode |=> ##1 transparent_active == $past(wsel, 2))
        else $error("transparent select wrong");
    chk_gated_bits: assert property (!transparent_active |->
        !(outside_sync_select || no_sync_select || bit_order_reverse))
        else $error("protocol bits active outside transparent mode");
    chk_irq_rise: assert property ($rose(irq) |-> $past(ev_any, 2) || $past(wr_en, 2))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(irq) |-> $past(wr_evt, 2) || $past(wr_en, 2))
        else $error("interrupt fell without clear");
endmodule : tscr_regs_monitor
bind tscr_regs tscr_regs_monitor #(.TRANSPARENT_SEL(TRANSPARENT_SEL)) u_tscr_regs_monitor (.ref_clk(ref_clk),
    .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .event_pulse(event_pulse), .common_mode(common_mode), .transparent_active(transparent_active),
    .outside_sync_select(outside_sync_select), .no_sync_select(no_sync_select),
    .bit_order_reverse(bit_order_reverse), .irq(irq));
`default_nettype wire

// ---- dv/tscr_regs_tb_top.sv ----
// Self-checking testbench for the register bank.
`timescale 1ns/1ps
`default_nettype none
module tscr_regs_tb_top
    import tscr_pkg::*;
;
    logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
    logic transparent_active, outside_sync_select, no_sync_select, bit_order_reverse;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
    logic [BE_W-1:0] avs_byteenable;
    logic [EVT_W-1:0] event_pulse;
    logic [MODE_COMMON_W-1:0] common_mode;
    int errors, checks_done, cycles, irq_rises;
    tscr_regs u_tscr_regs (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_pulse(event_pulse),
        .common_mode(common_mode), .transparent_active(transparent_active),
        .outside_sync_select(outside_sync_select), .no_sync_select(no_sync_select),
        .bit_order_reverse(bit_order_reverse), .irq(irq));
    tscr_host_irq u_tscr_host_irq (.ref_clk(ref_clk), .reset_n(reset_n), .irq(irq), .irq_rises(irq_rises));
    // ============================================================
    // Clock, timeout and shared tasks
    always #2.5 ref_clk = !ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Holds the request until waitrequest is seen low; ev pulses events over the same edges.
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [7:0] ev);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        event_pulse <= ev;
        do tick(1); while (avs_waitrequest !== 1'b0);
        @(posedge ref_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        event_pulse <= 8'h00;
        #1;
    endtask : bus
    // ============================================================
    // Scenarios
    task t_reset;
        bus(1'b0, ADDR_MODE, 32'h0, 8'h01);
        bus(1'b0, ADDR_EVENT, 32'h0, 8'h00);
        check(q, 32'h01);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        check(32'(irq), 32'h0);
        bus(1'b0, ADDR_MODE, 32'h0, 8'h00);
        check(q, 32'h0);
        bus(1'b0, ADDR_EVENT, 32'h0, 8'h00);
        check(q, 32'h0);
        bus(1'b0, ADDR_ENABLE, 32'h0, 8'h00);
        check(q, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task t_mode;
        bus(1'b1, ADDR_MODE, 32'h7003, 8'h00);
        tick(2);
        check(32'({transparent_active, outside_sync_select, no_sync_select, bit_order_reverse}), 32'hF);
        check(32'(common_mode), 32'h3);
        bus(1'b0, ADDR_MODE, 32'h0, 8'h00);
        check(q, 32'h7003);
        bus(1'b1, ADDR_MODE, 32'h7000, 8'h00);
        tick(2);
        check(32'({transparent_active, outside_sync_select, no_sync_select, bit_order_reverse}), 32'h0);
        $display("mode test done");
    endtask : t_mode
    task t_event;
        bus(1'b0, ADDR_MODE, 32'h0, 8'hFF);
        tick(2);
        check(32'(irq), 32'h0);
        bus(1'b0, ADDR_EVENT, 32'h0, 8'h00);
        check(q, 32'hDF);
        bus(1'b1, ADDR_ENABLE, 32'h01, 8'h00);
        tick(2);
        check(32'(irq), 32'h1);
        bus(1'b1, ADDR_EVENT, 32'h00, 8'h00);
        bus(1'b0, ADDR_EVENT, 32'h0, 8'h00);
        check(q, 32'hDF);
        bus(1'b1, ADDR_EVENT, 32'hDE, 8'h00);
        bus(1'b0, ADDR_EVENT, 32'h0, 8'h00);
        check(q, 32'h01);
        check(32'(irq), 32'h1);
        bus(1'b1, ADDR_EVENT, 32'h01, 8'h01);
        bus(1'b0, ADDR_EVENT, 32'h0, 8'h00);
        check(q, 32'h01);
        bus(1'b1, ADDR_EVENT, 32'h01, 8'h00);
        tick(2);
        check(32'(irq), 32'h0);
        check(32'(irq_rises), 32'h1);
        bus(1'b0, ADDR_ENABLE, 32'h0, 8'h00);
        check(q, 32'h01);
        $display("event test done");
    endtask : t_event
    task t_space;
        bus(1'b1, 10'h270, 32'hFFFF, 8'h00);
        bus(1'b0, 10'h270, 32'h0, 8'h00);
        check(q, 32'h0);
        bus(1'b0, 10'h2F8, 32'h0, 8'h00);
        check(q, 32'h0);
        bus(1'b0, 10'h00C, 32'h0, 8'h00);
        check(q, 32'h0);
        $display("space test done");
    endtask : t_space
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        {ref_clk, reset_n, avs_read, avs_write, avs_address, avs_writedata, event_pulse} = '0;
        avs_byteenable = 4'hF;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_space();
        t_mode();
        t_event();
        t_reset();
        finish_test();
    end
endmodule : tscr_regs_tb_top
`default_nettype wire
